//--- shared/vlpc_regs.svh
// Register offsets, field positions, reset values and timing counts of the link block
`ifndef VLPC_REGS_SVH
`define VLPC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VLPC_RATE_WIDTH_CONFIG 4'h0
`define VLPC_SPREAD_CONFIG 4'h1
`define VLPC_START_TIMEOUT_CONFIG 4'h2
`define VLPC_END_TIMEOUT_CONFIG 4'h3
`define VLPC_EDGE_POWER_CONTROL 4'h4
`define VLPC_OWN_LINK_ADDRESS 4'h5
`define VLPC_END_FRAME_CODE 4'h6
`define VLPC_PARTNER_LINK_ADDRESS 4'h7
`define VLPC_PERIPHERAL_IF_CONFIG 4'h8
`define VLPC_TEST_LEN_UPPER_PINS 4'h9
`define VLPC_PIN_DIRECTION_LOW 4'hA
`define VLPC_PIN_VALUE_LOW 4'hB
`define VLPC_LINE_EMPHASIS 4'hC
`define VLPC_GLITCH_FILTER_CONFIG 4'hD
`define VLPC_LINK_LOCK_STATUS 4'hE
`define VLPC_NUM_REGS 15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VLPC_RST_RATE_WIDTH 8'hB5
`define VLPC_RST_SPREAD 8'h1F
`define VLPC_RST_START_TIMEOUT 8'hA0
`define VLPC_RST_END_TIMEOUT 8'hA0
`define VLPC_RST_EDGE_POWER_REM_LOW 8'h28
`define VLPC_RST_EDGE_POWER_REM_HIGH 8'h30
`define VLPC_RST_OWN_ADDRESS 8'hFA
`define VLPC_RST_END_FRAME 8'hFF
`define VLPC_RST_PARTNER_ADDRESS 8'hF8
`define VLPC_RST_PERIPHERAL_IF 8'h00
`define VLPC_RST_TEST_LEN_PINS 8'h00
`define VLPC_RST_PIN_DIR_LOW 8'h00
`define VLPC_RST_PIN_VAL_LOW 8'h00
`define VLPC_RST_LINE_EMPHASIS 8'hE0
`define VLPC_RST_GLITCH_FILTER 8'h00
`define VLPC_RST_LOCK_STATUS 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VLPC_PARITY_ON_BIT 3
`define VLPC_WORD_WIDTH_LSB 0
`define VLPC_TIMEOUT_DIVIDER_LSB 4
`define VLPC_TIMEOUT_COUNT_LSB 0
`define VLPC_VSYNC_EDGE_BIT 7
`define VLPC_PCLK_EDGE_BIT 5
`define VLPC_POWER_DOWN_BIT 4
`define VLPC_SERIALIZER_ON_BIT 3
`define VLPC_JITTER_BYPASS_BIT 2
`define VLPC_PRBS_ON_BIT 0
`define VLPC_BUS_SELECT_BIT 7
`define VLPC_BUS_ON_BIT 6
`define VLPC_PRBS_LEN_LSB 4
`define VLPC_EMPHASIS_LSB 5
`define VLPC_FILTER_SELECT_LSB 0
`define VLPC_LOCKED_BIT 0

// ----------------------------------------------------------------
// Coding, handshake and timing
// ----------------------------------------------------------------
`define VLPC_CODING_BIT_ZERO 1'b1
`define VLPC_CODING_BIT_ONE 1'b0
`define VLPC_HSK_SHORT_WORDS 11'd546
`define VLPC_HSK_LONG_WORDS 11'd1090
`define VLPC_HSK_PATTERN 22'h2AAAAA
`define VLPC_CLK_MHZ 40
`define VLPC_FILT_SLOW_NS 100
`define VLPC_FILT_MID_NS 50
`define VLPC_FILT_FAST_NS 10
`define VLPC_NS_TO_CYC(ns) (((ns) * `VLPC_CLK_MHZ / 1000) < 1 ? 1 : ((ns) * `VLPC_CLK_MHZ / 1000))

`endif

//--- shared/vlpc_pkg.sv
// Types shared by the link phase and configuration block
package vlpc_pkg;
	typedef enum logic [1:0] {
		VLPC_VIDEO = 2'b00,
		VLPC_CHANNEL = 2'b01,
		VLPC_HANDSHAKE = 2'b10
	} vlpc_phase_t;

	typedef logic [21:0] vlpc_word_t;
	typedef logic [4:0] vlpc_len_t;
endpackage

//--- shared/vlpc_word_if.sv
// Framed serial word carrier between the block's own modules
`timescale 1ns/100ps
interface vlpc_word_if;
	logic [21:0] word;
	logic [4:0] len;
	logic valid;
	logic ready;
	modport src (output word, output len, output valid, input ready);
	modport snk (input word, input len, input valid, output ready);
endinterface

//--- design/vlpc_fifo.sv
// Word FIFO between framing logic and the bit shifter
`timescale 1ns/100ps
module vlpc_fifo import vlpc_pkg::*; #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	vlpc_word_if.snk in_port,
	vlpc_word_if.src out_port
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} vlpc_fifo_state_t;

	vlpc_fifo_state_t st;
	vlpc_fifo_state_t next_st;
	logic push;
	logic pop;

	assign in_port.ready = (st.count != (AW+1)'(DEPTH));
	assign out_port.valid = (st.count != '0);
	assign {out_port.len, out_port.word} = st.mem[st.rd_ptr];
	assign push = in_port.valid & in_port.ready;
	assign pop = out_port.valid & out_port.ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr_ptr] = {in_port.len, in_port.word};
			next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH-1)) ? '0 : st.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH-1)) ? '0 : st.rd_ptr + 1'b1;
		end
		next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
		if (!i_rstn) begin
			next_st.wr_ptr = '0;
			next_st.rd_ptr = '0;
			next_st.count = '0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		st <= next_st;
	end
endmodule

//--- design/vlpc_shifter.sv
// Bit shifter: sends each framed word least significant bit first
`timescale 1ns/100ps
module vlpc_shifter import vlpc_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	vlpc_word_if.snk word_in,
	output logic o_ser_bit,
	output logic o_ser_valid
);
	typedef struct packed {
		vlpc_word_t shreg;
		vlpc_len_t left;
	} vlpc_shift_state_t;

	vlpc_shift_state_t st;
	vlpc_shift_state_t next_st;

	// Taking a word on the last bit keeps words back to back
	assign word_in.ready = (st.left <= 5'd1);
	assign o_ser_bit = st.shreg[0];
	assign o_ser_valid = (st.left != 5'd0);

	always_comb begin
		next_st = st;
		if (word_in.valid && word_in.ready) begin
			next_st.shreg = word_in.word;
			next_st.left = word_in.len;
		end else if (st.left != 5'd0) begin
			next_st.shreg = {1'b0, st.shreg[21:1]};
			next_st.left = st.left - 5'd1;
		end
		if (!i_rstn) begin
			next_st.shreg = '0;
			next_st.left = '0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		st <= next_st;
	end
endmodule

//--- design/vlpc_top.sv
// Link phase sequencer, word framer and power-up register bank
//
// Summary of operation
// - Add two coding bits, two more with parity
// - No parity: coding bit zero goes first
// - Parity on: both parity bits go first
// - Active vsync edge opens the control channel
// - Channel-open flag high during control phase
// - Timers bound channel, control activity restarts them
// - Send 546 or 1090 handshake words after channel
// - Video resumes only after full handshake
// - Recovered data valid on programmed clock edge
// - Rate and width register resets to B5
// - Start timeout resets to divide 1024, count one
// - End timeout resets to divide 1024, count one
// - Edge/power resets 28 or 30 by remote pin
// - Falling vsync, rising clock, loop on, test off
// - Addresses FA and F8, end code FF
// - Peripheral UART, off, slow, never return, rate 00
// - Test length 0000, upper pins inputs, zero
// - Low pins all inputs, values zero
// - Emphasis 111, rest of register zero
// - Glitch filter 100, 50 or 10 ns; 10 ns rounds up to one 25 ns clock
`timescale 1ns/100ps
`include "vlpc_regs.svh"
module vlpc_top import vlpc_pkg::*; #(
	parameter int FIFO_DEPTH = 8,
	parameter int MAX_WIDTH = 18
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [17:0] i_pix_data,
	input wire logic i_pix_valid,
	output logic o_pix_ready,
	input wire logic i_vsync,
	input wire logic i_control_unit_activity,
	input wire logic i_remote_select_pin,
	input wire logic i_link_locked,
	input wire logic i_hsk_long,
	input wire logic i_two_wire_data,
	output logic o_two_wire_data,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_ser_bit,
	output logic o_ser_valid,
	output logic o_channel_open_flag,
	output logic o_sync_handshake,
	output logic o_pixel_clock_edge_select,
	output logic o_power_down,
	output logic o_jitter_loop_bypass,
	output logic o_pseudo_random_test_on,
	output logic [3:0] o_pseudo_random_length,
	output logic o_peripheral_bus_select,
	output logic o_peripheral_bus_on,
	output logic [2:0] o_line_emphasis_level,
	output logic [9:0] o_pin_dir,
	output logic [9:0] o_pin_val
);
	// ----------------------------------------------------------------
	// Constants and state
	// ----------------------------------------------------------------
	localparam logic [2:0] FILT_SLOW_CYC = 3'(`VLPC_NS_TO_CYC(`VLPC_FILT_SLOW_NS));
	localparam logic [2:0] FILT_MID_CYC = 3'(`VLPC_NS_TO_CYC(`VLPC_FILT_MID_NS));
	localparam logic [2:0] FILT_FAST_CYC = 3'(`VLPC_NS_TO_CYC(`VLPC_FILT_FAST_NS));

	typedef struct packed {
		vlpc_phase_t phase;
		logic [`VLPC_NUM_REGS-1:0][7:0] regs;
		logic [1:0] vs_sync;
		logic vs_prev;
		logic [1:0] act_sync;
		logic act_prev;
		logic [1:0] rem_sync;
		logic [1:0] strap_cnt;
		logic [1:0] lock_sync;
		logic [1:0] tw_sync;
		logic tw_filt;
		logic [2:0] tw_cnt;
		logic [15:0] presc;
		logic [3:0] timer;
		logic [10:0] hsk_cnt;
		logic [7:0] rdata;
	} vlpc_top_state_t;

	vlpc_top_state_t st;
	vlpc_top_state_t next_st;

	vlpc_word_if frame_if();
	vlpc_word_if shift_if();

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [3:0] addr);
		reg_hit = (addr <= `VLPC_LINK_LOCK_STATUS);
	endfunction

	function automatic logic [4:0] width_of(input logic [2:0] code);
		case (code)
			3'b001: width_of = 5'd10;
			3'b010: width_of = 5'd12;
			3'b011: width_of = 5'd14;
			3'b100: width_of = 5'd16;
			default: width_of = 5'd18;
		endcase
	endfunction

	function automatic logic [4:0] frame_len(input logic [2:0] code, input logic par);
		frame_len = width_of(code) + 5'd2 + (par ? 5'd2 : 5'd0);
	endfunction

	function automatic vlpc_word_t frame_word(input logic [17:0] d, input logic [2:0] code,
		input logic par);
		logic [17:0] masked;
		logic [19:0] body;
		logic p0;
		logic p1;
		masked = '0;
		for (int i = 0; i < MAX_WIDTH; i++) begin
			masked[i] = (5'(i) < width_of(code)) ? d[i] : 1'b0;
		end
		body = {masked, `VLPC_CODING_BIT_ONE, `VLPC_CODING_BIT_ZERO};
		p0 = 1'b0;
		p1 = 1'b0;
		for (int i = 0; i < 20; i += 2) begin
			p0 = p0 ^ body[i];
			p1 = p1 ^ body[i+1];
		end
		frame_word = par ? {body, p1, p0} : {2'b00, body};
	endfunction

	// ----------------------------------------------------------------
	// Register fields
	// ----------------------------------------------------------------
	logic parity_on;
	logic [2:0] word_width_code;
	logic [3:0] start_timeout_divider;
	logic [3:0] start_timeout_count;
	logic [3:0] end_timeout_divider;
	logic [3:0] end_timeout_count;
	logic vsync_edge_select;
	logic serializer_on;
	logic [1:0] two_wire_filter_select;
	logic [7:0] edge_reg;

	assign parity_on = st.regs[`VLPC_RATE_WIDTH_CONFIG][`VLPC_PARITY_ON_BIT];
	assign word_width_code = st.regs[`VLPC_RATE_WIDTH_CONFIG][`VLPC_WORD_WIDTH_LSB +: 3];
	assign start_timeout_divider =
		st.regs[`VLPC_START_TIMEOUT_CONFIG][`VLPC_TIMEOUT_DIVIDER_LSB +: 4];
	assign start_timeout_count = st.regs[`VLPC_START_TIMEOUT_CONFIG][`VLPC_TIMEOUT_COUNT_LSB +: 4];
	assign end_timeout_divider = st.regs[`VLPC_END_TIMEOUT_CONFIG][`VLPC_TIMEOUT_DIVIDER_LSB +: 4];
	assign end_timeout_count = st.regs[`VLPC_END_TIMEOUT_CONFIG][`VLPC_TIMEOUT_COUNT_LSB +: 4];
	assign edge_reg = st.regs[`VLPC_EDGE_POWER_CONTROL];
	assign vsync_edge_select = edge_reg[`VLPC_VSYNC_EDGE_BIT];
	assign serializer_on = edge_reg[`VLPC_SERIALIZER_ON_BIT] & ~edge_reg[`VLPC_POWER_DOWN_BIT];
	assign two_wire_filter_select =
		st.regs[`VLPC_GLITCH_FILTER_CONFIG][`VLPC_FILTER_SELECT_LSB +: 2];

	assign o_pixel_clock_edge_select = edge_reg[`VLPC_PCLK_EDGE_BIT];
	assign o_power_down = edge_reg[`VLPC_POWER_DOWN_BIT];
	assign o_jitter_loop_bypass = edge_reg[`VLPC_JITTER_BYPASS_BIT];
	assign o_pseudo_random_test_on = edge_reg[`VLPC_PRBS_ON_BIT];
	assign o_pseudo_random_length = st.regs[`VLPC_TEST_LEN_UPPER_PINS][`VLPC_PRBS_LEN_LSB +: 4];
	assign o_peripheral_bus_select = st.regs[`VLPC_PERIPHERAL_IF_CONFIG][`VLPC_BUS_SELECT_BIT];
	assign o_peripheral_bus_on = st.regs[`VLPC_PERIPHERAL_IF_CONFIG][`VLPC_BUS_ON_BIT];
	assign o_line_emphasis_level = st.regs[`VLPC_LINE_EMPHASIS][`VLPC_EMPHASIS_LSB +: 3];
	assign o_pin_dir = {st.regs[`VLPC_TEST_LEN_UPPER_PINS][3:2],
		st.regs[`VLPC_PIN_DIRECTION_LOW]};
	assign o_pin_val = {st.regs[`VLPC_TEST_LEN_UPPER_PINS][1:0], st.regs[`VLPC_PIN_VALUE_LOW]};
	assign o_reg_rdata = st.rdata;
	assign o_two_wire_data = st.tw_filt;
	assign o_channel_open_flag = (st.phase == VLPC_CHANNEL);
	assign o_sync_handshake = (st.phase == VLPC_HANDSHAKE);

	// ----------------------------------------------------------------
	// Word source into the FIFO
	// ----------------------------------------------------------------
	logic pix_take;
	logic hsk_push;
	logic [4:0] cur_len;

	assign cur_len = frame_len(word_width_code, parity_on);
	assign o_pix_ready = (st.phase == VLPC_VIDEO) & serializer_on & frame_if.ready;
	assign pix_take = o_pix_ready & i_pix_valid;
	assign hsk_push = (st.phase == VLPC_HANDSHAKE) & frame_if.ready;
	assign frame_if.valid = pix_take | hsk_push;
	assign frame_if.len = cur_len;
	assign frame_if.word = hsk_push ? (`VLPC_HSK_PATTERN & ((22'h1 << cur_len) - 22'h1)) :
		frame_word(i_pix_data, word_width_code, parity_on);

	vlpc_fifo #(
		.WIDTH(27),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.in_port(frame_if),
		.out_port(shift_if)
	);

	vlpc_shifter u_shifter (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.word_in(shift_if),
		.o_ser_bit(o_ser_bit),
		.o_ser_valid(o_ser_valid)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic vs_edge;
	logic act_edge;
	logic tick;
	logic [3:0] cur_div;
	logic [2:0] filt_cyc;
	logic [10:0] hsk_words;

	// Vsync is only assumed stable eight clocks after its edge, so only one edge is used
	assign vs_edge = vsync_edge_select ? (st.vs_sync[1] & ~st.vs_prev) :
		(~st.vs_sync[1] & st.vs_prev);
	assign act_edge = st.act_sync[1] ^ st.act_prev;
	assign cur_div = (st.hsk_cnt[0]) ? end_timeout_divider : start_timeout_divider;
	assign tick = (st.presc == 16'((17'h1 << cur_div) - 17'h1));
	assign hsk_words = i_hsk_long ? `VLPC_HSK_LONG_WORDS : `VLPC_HSK_SHORT_WORDS;

	always_comb begin
		case (two_wire_filter_select)
			2'b00: filt_cyc = FILT_SLOW_CYC;
			2'b01: filt_cyc = FILT_MID_CYC;
			default: filt_cyc = FILT_FAST_CYC;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.vs_sync = {st.vs_sync[0], i_vsync};
		next_st.vs_prev = st.vs_sync[1];
		next_st.act_sync = {st.act_sync[0], i_control_unit_activity};
		next_st.act_prev = st.act_sync[1];
		next_st.rem_sync = {st.rem_sync[0], i_remote_select_pin};
		next_st.lock_sync = {st.lock_sync[0], i_link_locked};
		next_st.tw_sync = {st.tw_sync[0], i_two_wire_data};

		// Pulses no longer than the selected width never reach the output
		if (st.tw_sync[1] == st.tw_filt) begin
			next_st.tw_cnt = '0;
		end else if (st.tw_cnt == filt_cyc) begin
			next_st.tw_filt = st.tw_sync[1];
			next_st.tw_cnt = '0;
		end else begin
			next_st.tw_cnt = st.tw_cnt + 3'd1;
		end

		// Strap is caught once the synchroniser has filled after release
		if (st.strap_cnt != 2'd0) begin
			next_st.strap_cnt = st.strap_cnt - 2'd1;
			if (st.strap_cnt == 2'd1) begin
				next_st.regs[`VLPC_EDGE_POWER_CONTROL] = st.rem_sync[1] ?
					`VLPC_RST_EDGE_POWER_REM_HIGH : `VLPC_RST_EDGE_POWER_REM_LOW;
			end
		end

		next_st.regs[`VLPC_LINK_LOCK_STATUS] = {7'h00, st.lock_sync[1]};

		if (i_reg_wr && reg_hit(i_reg_addr) && i_reg_addr != `VLPC_LINK_LOCK_STATUS) begin
			next_st.regs[i_reg_addr] = i_reg_wdata;
		end
		if (i_reg_rd) begin
			next_st.rdata = reg_hit(i_reg_addr) ? st.regs[i_reg_addr] : 8'h00;
		end

		// Phase sequencing; hsk_cnt[0] marks end timing inside the channel phase
		case (st.phase)
			VLPC_VIDEO: begin
				next_st.presc = '0;
				next_st.hsk_cnt = '0;
				next_st.timer = start_timeout_count;
				if (vs_edge) begin
					next_st.phase = VLPC_CHANNEL;
				end
			end
			VLPC_CHANNEL: begin
				next_st.presc = tick ? 16'h0000 : st.presc + 16'h0001;
				if (act_edge) begin
					next_st.presc = '0;
					next_st.timer = end_timeout_count;
					next_st.hsk_cnt = 11'd1;
				end else if (tick) begin
					if (st.timer == 4'd0) begin
						next_st.phase = VLPC_HANDSHAKE;
						next_st.hsk_cnt = '0;
					end else begin
						next_st.timer = st.timer - 4'd1;
					end
				end
			end
			VLPC_HANDSHAKE: begin
				if (hsk_push) begin
					next_st.hsk_cnt = st.hsk_cnt + 11'd1;
					if (st.hsk_cnt == hsk_words - 11'd1) begin
						next_st.phase = VLPC_VIDEO;
					end
				end
			end
			default: begin
				next_st.phase = VLPC_VIDEO;
			end
		endcase

		if (!i_rstn) begin
			next_st = '0;
			next_st.phase = VLPC_VIDEO;
			next_st.strap_cnt = 2'd3;
			next_st.timer = 4'd0;
			next_st.regs[`VLPC_RATE_WIDTH_CONFIG] = `VLPC_RST_RATE_WIDTH;
			next_st.regs[`VLPC_SPREAD_CONFIG] = `VLPC_RST_SPREAD;
			next_st.regs[`VLPC_START_TIMEOUT_CONFIG] = `VLPC_RST_START_TIMEOUT;
			next_st.regs[`VLPC_END_TIMEOUT_CONFIG] = `VLPC_RST_END_TIMEOUT;
			next_st.regs[`VLPC_EDGE_POWER_CONTROL] = `VLPC_RST_EDGE_POWER_REM_LOW;
			next_st.regs[`VLPC_OWN_LINK_ADDRESS] = `VLPC_RST_OWN_ADDRESS;
			next_st.regs[`VLPC_END_FRAME_CODE] = `VLPC_RST_END_FRAME;
			next_st.regs[`VLPC_PARTNER_LINK_ADDRESS] = `VLPC_RST_PARTNER_ADDRESS;
			next_st.regs[`VLPC_PERIPHERAL_IF_CONFIG] = `VLPC_RST_PERIPHERAL_IF;
			next_st.regs[`VLPC_TEST_LEN_UPPER_PINS] = `VLPC_RST_TEST_LEN_PINS;
			next_st.regs[`VLPC_PIN_DIRECTION_LOW] = `VLPC_RST_PIN_DIR_LOW;
			next_st.regs[`VLPC_PIN_VALUE_LOW] = `VLPC_RST_PIN_VAL_LOW;
			next_st.regs[`VLPC_LINE_EMPHASIS] = `VLPC_RST_LINE_EMPHASIS;
			next_st.regs[`VLPC_GLITCH_FILTER_CONFIG] = `VLPC_RST_GLITCH_FILTER;
			next_st.regs[`VLPC_LINK_LOCK_STATUS] = `VLPC_RST_LOCK_STATUS;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		st <= next_st;
	end
endmodule

//--- dv/vlpc_top_properties.sv
// Concurrent checks on the link block's top-level ports
`timescale 1ns/100ps
module vlpc_top_properties import vlpc_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_reg_rd,
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_pix_ready,
	input wire logic o_channel_open_flag,
	input wire logic o_sync_handshake,
	input wire logic o_power_down,
	input wire logic [2:0] o_line_emphasis_level,
	input wire logic [9:0] o_pin_dir
);
	// Saturates so a stuck handshake cannot wrap back below the bound
	logic [10:0] hsk_len;
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn || !o_sync_handshake) begin
			hsk_len <= 11'h000;
		end else if (hsk_len != 11'h7FF) begin
			hsk_len <= hsk_len + 11'h001;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	AST_READY_ONLY_VIDEO: assert property (o_pix_ready |->
		!o_channel_open_flag && !o_sync_handshake)
		else $error("pixel ready outside video phase");
	AST_PHASES_EXCLUSIVE: assert property (!(o_channel_open_flag && o_sync_handshake))
		else $error("channel and handshake both active");
	AST_CHANNEL_FROM_VIDEO: assert property ($rose(o_channel_open_flag) |->
		$past(!o_sync_handshake))
		else $error("channel opened from handshake");
	AST_HSK_FOLLOWS_CHANNEL: assert property ($fell(o_channel_open_flag) |-> o_sync_handshake)
		else $error("no handshake after channel");
	AST_HSK_LENGTH: assert property ($fell(o_sync_handshake) |-> hsk_len >= 11'd545)
		else $error("handshake too short");
	AST_HSK_TO_VIDEO: assert property ($fell(o_sync_handshake) |-> !o_channel_open_flag [*4])
		else $error("channel after handshake");
	AST_LOCK_READ_ONLY: assert property (i_reg_rd && i_reg_addr == 4'hE |=>
		o_reg_rdata[7:1] == 7'h00)
		else $error("status reserved bits set");
	AST_RDATA_HOLDS: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data changed without read");
	AST_POWER_DOWN_STOPS: assert property (o_power_down |-> !o_pix_ready)
		else $error("ready while powered down");
	AST_RESET_OUTPUTS: assert property ($rose(i_rstn) |->
		o_line_emphasis_level == 3'h7 && o_pin_dir == 10'h000)
		else $error("config outputs not at reset values");
endmodule
bind vlpc_top vlpc_top_properties i_props (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
	.i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
	.o_pix_ready(o_pix_ready), .o_channel_open_flag(o_channel_open_flag),
	.o_sync_handshake(o_sync_handshake), .o_power_down(o_power_down),
	.o_line_emphasis_level(o_line_emphasis_level), .o_pin_dir(o_pin_dir));

//--- dv/vlpc_deser_model.sv
// Behavioural deserializer: reframes the serial bit stream into words
`timescale 1ns/100ps
module vlpc_deser_model (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_ser_bit,
	input wire logic i_ser_valid,
	input wire logic [4:0] i_len,
	output logic [21:0] o_word,
	output logic o_word_stb,
	output logic o_locked
);
	logic [21:0] acc;
	logic [21:0] nxt;
	logic [4:0] cnt;
	// Framing trusts the length the bench sets; no boundary search
	always @(posedge i_core_clk) begin
		o_word_stb <= 1'b0;
		if (!i_rstn) begin
			cnt <= 5'h00;
			acc <= 22'h000000;
			o_locked <= 1'b0;
		end else if (i_ser_valid) begin
			nxt = acc;
			nxt[cnt] = i_ser_bit;
			if (cnt == i_len - 5'h01) begin
				o_word <= nxt;
				o_word_stb <= 1'b1;
				o_locked <= 1'b1;
				acc <= 22'h000000;
				cnt <= 5'h00;
			end else begin
				acc <= nxt;
				cnt <= cnt + 5'h01;
			end
		end
	end
endmodule

//--- dv/video_link_phase_and_config_bench.sv
// Self-checking bench for the link phase and configuration block
`timescale 1ns/100ps
module video_link_phase_and_config_bench;
	logic clk = 1'b0, rstn = 1'b0, pix_valid = 1'b0, vsync = 1'b1, act = 1'b0, remote_select_pin = 1'b0;
	logic hsk_long = 1'b0, tw_in = 1'b0, wr = 1'b0, rd = 1'b0, tw_seen = 1'b0;
	logic [17:0] pix_data = 18'h00000;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [4:0] mlen = 5'h14;
	wire logic ready, tw_out, ser_bit, ser_valid, chan, sync_handshake, pd, locked, stb;
	wire logic [7:0] rdata;
	wire logic [21:0] rx_word;
	int failures = 0, checked = 0, seed = 32'h7DF9, cyc = 0, stalls = 0;
	int thr [4] = '{4, 2, 1, 1};
	logic [7:0] dflt [15] = '{8'hB5, 8'h1F, 8'hA0, 8'hA0, 8'h28, 8'hFA, 8'hFF, 8'hF8,
		8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, 8'h00, 8'h00};
	logic [21:0] rx_q [$];
	logic [21:0] exp_q [$];
	vlpc_top i_dut (.i_core_clk(clk), .i_rstn(rstn), .i_pix_data(pix_data),
		.i_pix_valid(pix_valid), .o_pix_ready(ready), .i_vsync(vsync),
		.i_control_unit_activity(act), .i_remote_select_pin(remote_select_pin), .i_link_locked(locked),
		.i_hsk_long(hsk_long), .i_two_wire_data(tw_in), .o_two_wire_data(tw_out),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_ser_bit(ser_bit), .o_ser_valid(ser_valid),
		.o_channel_open_flag(chan), .o_sync_handshake(sync_handshake), .o_pixel_clock_edge_select(),
		.o_power_down(pd), .o_jitter_loop_bypass(), .o_pseudo_random_test_on(),
		.o_pseudo_random_length(), .o_peripheral_bus_select(), .o_peripheral_bus_on(),
		.o_line_emphasis_level(), .o_pin_dir(), .o_pin_val());
	vlpc_deser_model i_far (.i_core_clk(clk), .i_rstn(rstn), .i_ser_bit(ser_bit),
		.i_ser_valid(ser_valid), .i_len(mlen), .o_word(rx_word), .o_word_stb(stb),
		.o_locked(locked));
	always #12.5 clk = ~clk;
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (stb) rx_q.push_back(rx_word);
		if (tw_out === 1'b1) tw_seen <= 1'b1;
		if (cyc == 90000) begin
			failures++;
			$display("ERROR timeout expected end seen hang");
			tally_and_finish();
		end
	end
	task automatic check(string what, logic [21:0] seen, logic [21:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_wr(logic [3:0] a, logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic reg_rd(logic [3:0] a, output logic [7:0] d);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic push(logic [17:0] d);
		int n = 0;
		@(negedge clk);
		pix_data = d;
		pix_valid = 1'b1;
		while (ready !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
			stalls++;
		end
		@(negedge clk);
		pix_valid = 1'b0;
	endtask
	task automatic idle();
		int n = 0;
		while (n < 40) begin
			@(negedge clk);
			n = (ser_valid !== 1'b0) ? 0 : n + 1;
		end
	endtask
	task automatic pulse(int len, logic exp);
		@(negedge clk);
		tw_seen = 1'b0;
		tw_in = 1'b1;
		repeat (len) @(negedge clk);
		tw_in = 1'b0;
		repeat (20) @(negedge clk);
		check("filtered line", tw_seen, exp);
	endtask
	function automatic logic [21:0] frame(logic [17:0] d, int w, bit par);
		logic [19:0] b;
		logic p0 = 1'b0;
		logic p1 = 1'b0;
		b = {d, 2'b01} & ((20'h00001 << (w + 2)) - 20'h00001);
		for (int i = 0; i < 20; i += 2) begin
			p0 ^= b[i];
			p1 ^= b[i + 1];
		end
		return par ? {b, p1, p0} : {2'b00, b};
	endfunction
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] v;
		logic [31:0] r;
		int w;
		int n;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		for (int a = 0; a < 15; a++) begin
			reg_rd(a[3:0], v);
			check("reset value", v, dflt[a]);
		end
		for (int a = 0; a < 16; a++) begin
			r = $random(seed);
			reg_wr(a[3:0], r[7:0]);
			reg_rd(a[3:0], v);
			check("readback", v, (a >= 14) ? 8'h00 : r[7:0]);
			if (a < 15) reg_wr(a[3:0], dflt[a]);
		end
		$display("test registers done");
		for (int p = 0; p < 2; p++) begin
			for (int c = 1; c < 6; c++) begin
				w = 8 + 2 * c;
				reg_wr(4'h0, {4'hB, p[0], c[2:0]});
				mlen = 5'(w + 2 + 2 * p);
				for (int i = 0; i < 10; i++) begin
					r = $random(seed);
					exp_q.push_back(frame(r[17:0], w, p[0]));
					push(r[17:0]);
				end
				idle();
				check("word count", 22'(rx_q.size()), 22'd10);
				while (rx_q.size() > 0 && exp_q.size() > 0) begin
					check("serial word", rx_q.pop_front(), exp_q.pop_front());
				end
			end
		end
		check("fifo refused", 22'(stalls != 0), 22'd1);
		reg_wr(4'h0, 8'hB5);
		mlen = 5'h14;
		$display("test framing done");
		reg_wr(4'h2, 8'h43);
		reg_wr(4'h3, 8'h43);
		for (int h = 0; h < 2; h++) begin
			hsk_long = h[0];
			rx_q.delete();
			vsync = 1'b0;
			n = 0;
			while (chan !== 1'b1 && n < 10) begin
				@(negedge clk);
				n++;
			end
			check("channel open", chan, 1'b1);
			repeat (10) begin
				repeat (8) @(negedge clk);
				act = ~act;
			end
			vsync = 1'b1;
			check("channel held", chan, 1'b1);
			n = 0;
			while (sync_handshake !== 1'b1 && n < 200) begin
				@(negedge clk);
				n++;
			end
			n = 0;
			while (sync_handshake !== 1'b0 && n < 30000) begin
				@(negedge clk);
				n++;
			end
			idle();
			check("handshake words", 22'(rx_q.size()), h ? 22'd1090 : 22'd546);
			foreach (rx_q[i]) check("handshake pattern", rx_q[i], 22'h0AAAAA);
			check("video resumes", ready, 1'b1);
		end
		$display("test phases done");
		for (int c = 0; c < 4; c++) begin
			reg_wr(4'hD, c[7:0]);
			pulse(thr[c], 1'b0);
			pulse(thr[c] + 6, 1'b1);
		end
		$display("test filter done");
		reg_rd(4'hE, v);
		check("lock status", v, 8'h01);
		@(negedge clk);
		remote_select_pin = 1'b1;
		rstn = 1'b0;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		repeat (6) @(negedge clk);
		reg_rd(4'h4, v);
		check("remote reset value", v, 8'h30);
		check("powered down", pd, 1'b1);
		check("no pixel intake", ready, 1'b0);
		$display("test remote strap done");
		tally_and_finish();
	end
endmodule
